// file: src/dmpb_pkg.sv
/*
  Constants of the drive monitor parameter bank: object indices, shipped
  defaults, accepted ranges, status bit positions and timing.
  Assumes one 40 MHz system clock and a service-data request port.
*/
// How it works
// - Peak run torque, skipping start and brake-down
// - Logic supply voltage readable in 0.1 V
// - Motor supply voltage readable in 0.1 V
// - Run start only above threshold 180..240
// - Same threshold drives motor power bit 4
// - Running, voltage may sag to 17.5 V
// - Motor voltage averaged over 100..1000 ms
// - Writable temperature limit, default 70 degrees
// - Internal temperature readable in whole degrees
// - Build date read as year and week
// - Read-only 16-bit serial number
// - End-of-run holding torque for 0..1000 ms
// - Brake stays released for set delay
// - Drag correction trim limited, default 4
// - Drag trim maximum writable only at standstill
// - Standstill readjustment switch, default off
// - Status bit 7 flags temperature exceeded
package dmpb_pkg;
  // ****************************************
  // Object indices
  // ****************************************
  localparam logic [15:0] IDX_SPEED = 16'h2030;
  localparam logic [15:0] IDX_PEAK = 16'h2031;
  localparam logic [15:0] IDX_TORQUE = 16'h2033;
  localparam logic [15:0] IDX_ULOGIC = 16'h203a;
  localparam logic [15:0] IDX_UDRIVE = 16'h203b;
  localparam logic [15:0] IDX_THR = 16'h203c;
  localparam logic [15:0] IDX_WIN = 16'h203d;
  localparam logic [15:0] IDX_TLIM = 16'h203e;
  localparam logic [15:0] IDX_TEMP = 16'h203f;
  localparam logic [15:0] IDX_YW = 16'h2040;
  localparam logic [15:0] IDX_SERIAL = 16'h2041;
  localparam logic [15:0] IDX_HOLD_TQ = 16'h2042;
  localparam logic [15:0] IDX_HOLD_DUR = 16'h2043;
  localparam logic [15:0] IDX_BRAKE = 16'h2045;
  localparam logic [15:0] IDX_LAG = 16'h2046;
  localparam logic [15:0] IDX_REST = 16'h2047;
  // ****************************************
  // Shipped defaults and ranges
  // ****************************************
  localparam logic [15:0] RST_THR = 16'h00b9;
  localparam logic [15:0] RST_WIN = 16'h0064;
  localparam logic [15:0] RST_TLIM = 16'h0046;
  localparam logic [15:0] RST_HOLD_TQ = 16'h0000;
  localparam logic [15:0] RST_HOLD_DUR = 16'h00c8;
  localparam logic [15:0] RST_BRAKE = 16'h03e8;
  localparam logic [15:0] RST_LAG = 16'h0004;
  localparam logic [7:0] RST_REST = 8'h00;
  localparam logic [15:0] MIN_THR = 16'h00b4;
  localparam logic [15:0] MAX_THR = 16'h00f0;
  localparam logic [15:0] MIN_WIN = 16'h0064;
  localparam logic [15:0] MAX_WIN = 16'h03e8;
  localparam logic [15:0] MIN_TLIM = 16'h000a;
  localparam logic [15:0] MAX_TLIM = 16'h0050;
  localparam logic [15:0] MAX_HOLD_DUR = 16'h03e8;
  localparam logic [15:0] MAX_BRAKE = 16'h0bb8;
  localparam logic [15:0] MAX_LAG = 16'h000a;
  localparam logic [15:0] MAX_REST = 16'h0001;
  localparam logic [15:0] RUN_SAG_MIN = 16'h00af;  // 17.5 V in 0.1 V steps
  // ****************************************
  // Status bits and timing
  // ****************************************
  localparam int STAT_MPOW = 4;
  localparam int STAT_TEXC = 7;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
endpackage

// file: src/dmpb_bank.sv
/*
  Parameter and measurement object bank of a positioning drive.
  Assumes all measurement and run-phase inputs come from logic on
  clk_sys_i, and a backup store that replays saved objects after reset.
*/
`timescale 1ns/10ps
module dmpb_bank
  import dmpb_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Service data request and answer
  input wire logic sdo_req_i,
  input wire logic sdo_wr_i,
  input wire logic [15:0] sdo_index_i,
  input wire logic [15:0] sdo_wdata_i,
  output logic sdo_ack_o,
  output logic sdo_abort_o,
  output logic [15:0] sdo_rdata_o,
  // Measurements
  input wire logic [15:0] speed_i,
  input wire logic [15:0] torque_i,
  input wire logic [15:0] logic_volt_i,
  input wire logic [15:0] motor_volt_i,
  input wire logic [15:0] temp_i,
  // Identity straps, caught after reset
  input wire logic [15:0] year_week_format_i,
  input wire logic [15:0] serial_i,
  // Run phases from the motion control
  input wire logic run_active_i,
  input wire logic start_phase_i,
  input wire logic brake_phase_i,
  // Backup store
  input wire logic nv_wr_i,
  input wire logic [15:0] nv_index_i,
  input wire logic [15:0] nv_data_i,
  output logic nv_save_o,
  output logic [15:0] nv_index_o,
  output logic [15:0] nv_data_o,
  // Drive controls
  output logic run_permit_o,
  output logic [15:0] status_o,
  output logic hold_active_o,
  output logic [15:0] hold_torque_o,
  output logic brake_release_o,
  output logic [15:0] lag_trim_max_o,
  output logic rest_trim_en_o
);
  localparam int MSW = $clog2(CYC_PER_MS_P);

  typedef struct packed {
    logic ack;
    logic abort;
    logic [15:0] rdata;
    logic [15:0] thr;
    logic [15:0] win;
    logic [15:0] tlim;
    logic [15:0] hold_tq;
    logic [15:0] hold_dur;
    logic [15:0] brake;
    logic [15:0] lag;
    logic [7:0] rest;
    logic [15:0] peak;
    logic [15:0] avg;
    logic [25:0] sum;
    logic [15:0] win_cnt;
    logic [MSW-1:0] ms_cnt;
    logic [15:0] hold_ms;
    logic [15:0] brake_ms;
    logic run_d;
    logic permit;
    logic [15:0] status;
    logic hold_act;
    logic brk_rel;
    logic straps_done;
    logic [15:0] yw;
    logic [15:0] serial;
    logic nv_save;
    logic [15:0] nv_idx;
    logic [15:0] nv_data;
  } dmpb_state_t;

  dmpb_state_t s_ff;
  dmpb_state_t nxt_s;

  // ****************************************
  // Write acceptance
  // ****************************************
  // One table decides writability and range for master and backup alike
  function automatic logic wr_ok(input logic [15:0] idx, input logic [15:0] d,
                                 input logic moving);
    logic ok;
    ok = 1'b0;
    case (idx)
      IDX_THR: ok = (d >= MIN_THR) && (d <= MAX_THR);
      IDX_WIN: ok = (d >= MIN_WIN) && (d <= MAX_WIN);
      IDX_TLIM: ok = (d >= MIN_TLIM) && (d <= MAX_TLIM);
      IDX_HOLD_TQ: ok = 1'b1;
      IDX_HOLD_DUR: ok = (d <= MAX_HOLD_DUR);
      IDX_BRAKE: ok = (d <= MAX_BRAKE);
      IDX_LAG: ok = (d <= MAX_LAG) && !moving;
      IDX_REST: ok = (d <= MAX_REST);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  // Master requests take priority; a backup replay in the same cycle is lost
  always_comb begin
    logic [15:0] widx;
    logic [15:0] wdat;
    logic wen;
    logic accept;
    logic [25:0] total;
    logic ms_tick;
    logic valid_phase;
    nxt_s = s_ff;
    widx = sdo_req_i ? sdo_index_i : nv_index_i;
    wdat = sdo_req_i ? sdo_wdata_i : nv_data_i;
    wen = (sdo_req_i && sdo_wr_i) || (!sdo_req_i && nv_wr_i);
    accept = wen && wr_ok(widx, wdat, run_active_i);
    total = s_ff.sum + 26'(motor_volt_i);
    ms_tick = (s_ff.ms_cnt == MSW'(CYC_PER_MS_P - 1));
    valid_phase = run_active_i && !start_phase_i && !brake_phase_i;
    nxt_s.ack = 1'b0;
    nxt_s.abort = 1'b0;
    nxt_s.nv_save = 1'b0;
    nxt_s.run_d = run_active_i;

    // Identity straps are caught once, on the first cycle after release
    if (!s_ff.straps_done) begin
      nxt_s.straps_done = 1'b1;
      nxt_s.yw = year_week_format_i;
      nxt_s.serial = serial_i;
    end

    // Stored parameters; backup replay restores saved values
    if (accept) begin
      case (widx)
        IDX_THR: nxt_s.thr = wdat;
        IDX_WIN: nxt_s.win = wdat;
        IDX_TLIM: nxt_s.tlim = wdat;
        IDX_HOLD_TQ: nxt_s.hold_tq = wdat;
        IDX_HOLD_DUR: nxt_s.hold_dur = wdat;
        IDX_BRAKE: nxt_s.brake = wdat;
        IDX_LAG: nxt_s.lag = wdat;
        IDX_REST: nxt_s.rest = wdat[7:0];
        default: nxt_s.rest = s_ff.rest;
      endcase
    end

    // Master writes that stick are offered to the backup store
    if (accept && sdo_req_i) begin
      nxt_s.nv_save = 1'b1;
      nxt_s.nv_idx = widx;
      nxt_s.nv_data = wdat;
    end

    // Answer every request one cycle later, ack or abort
    if (sdo_req_i) begin
      nxt_s.rdata = 16'h0000;
      if (sdo_wr_i) begin
        nxt_s.ack = accept;
        nxt_s.abort = !accept;
      end else begin
        nxt_s.ack = 1'b1;
        case (sdo_index_i)
          IDX_SPEED: nxt_s.rdata = speed_i;
          IDX_PEAK: nxt_s.rdata = s_ff.peak;
          IDX_TORQUE: nxt_s.rdata = torque_i;
          IDX_ULOGIC: nxt_s.rdata = logic_volt_i;
          IDX_UDRIVE: nxt_s.rdata = s_ff.avg;
          IDX_THR: nxt_s.rdata = s_ff.thr;
          IDX_WIN: nxt_s.rdata = s_ff.win;
          IDX_TLIM: nxt_s.rdata = s_ff.tlim;
          IDX_TEMP: nxt_s.rdata = temp_i;
          IDX_YW: nxt_s.rdata = s_ff.yw;
          IDX_SERIAL: nxt_s.rdata = s_ff.serial;
          IDX_HOLD_TQ: nxt_s.rdata = s_ff.hold_tq;
          IDX_HOLD_DUR: nxt_s.rdata = s_ff.hold_dur;
          IDX_BRAKE: nxt_s.rdata = s_ff.brake;
          IDX_LAG: nxt_s.rdata = s_ff.lag;
          IDX_REST: nxt_s.rdata = {8'h00, s_ff.rest};
          default: begin
            nxt_s.ack = 1'b0;
            nxt_s.abort = 1'b1;
          end
        endcase
      end
    end

    // Millisecond divider
    nxt_s.ms_cnt = ms_tick ? '0 : s_ff.ms_cnt + MSW'(1);

    // Windowed average, one sample per ms; a window change takes
    // effect once the running count passes it
    if (ms_tick) begin
      if (s_ff.win_cnt + 16'h0001 >= s_ff.win) begin
        nxt_s.avg = 16'(total / 26'(s_ff.win));
        nxt_s.sum = '0;
        nxt_s.win_cnt = 16'h0000;
      end else begin
        nxt_s.sum = total;
        nxt_s.win_cnt = s_ff.win_cnt + 16'h0001;
      end
    end

    // Peak torque of the latest run, cleared when a run begins
    if (run_active_i && !s_ff.run_d) begin
      nxt_s.peak = 16'h0000;
    end else if (valid_phase && (torque_i > s_ff.peak)) begin
      nxt_s.peak = torque_i;
    end

    // End-of-run hold and brake timers, loaded on the first cycle after the run ends
    if (!run_active_i && s_ff.run_d) begin
      nxt_s.hold_ms = s_ff.hold_dur;
      nxt_s.brake_ms = s_ff.brake;
    end else if (run_active_i) begin
      nxt_s.hold_ms = 16'h0000;
      nxt_s.brake_ms = 16'h0000;
    end else if (ms_tick) begin
      nxt_s.hold_ms = (s_ff.hold_ms != 16'h0000) ? s_ff.hold_ms - 16'h0001 : 16'h0000;
      nxt_s.brake_ms = (s_ff.brake_ms != 16'h0000) ? s_ff.brake_ms - 16'h0001 : 16'h0000;
    end
    nxt_s.hold_act = (nxt_s.hold_ms != 16'h0000);
    nxt_s.brk_rel = run_active_i || (nxt_s.brake_ms != 16'h0000);

    // Start needs the threshold; a started run tolerates the sag floor
    if (run_active_i) begin
      nxt_s.permit = (s_ff.avg >= RUN_SAG_MIN);
    end else begin
      nxt_s.permit = (s_ff.avg > s_ff.thr);
    end

    // Status word bits owned here
    nxt_s.status = 16'h0000;
    nxt_s.status[STAT_MPOW] = (s_ff.avg > s_ff.thr);
    nxt_s.status[STAT_TEXC] = ($signed(temp_i) > $signed(s_ff.tlim));
  end

  // ****************************************
  // State register
  // ****************************************
  // Shipped defaults until the backup store replays saved values
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.thr <= RST_THR;
      s_ff.win <= RST_WIN;
      s_ff.tlim <= RST_TLIM;
      s_ff.hold_tq <= RST_HOLD_TQ;
      s_ff.hold_dur <= RST_HOLD_DUR;
      s_ff.brake <= RST_BRAKE;
      s_ff.lag <= RST_LAG;
      s_ff.rest <= RST_REST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign sdo_ack_o = s_ff.ack;
  assign sdo_abort_o = s_ff.abort;
  assign sdo_rdata_o = s_ff.rdata;
  assign nv_save_o = s_ff.nv_save;
  assign nv_index_o = s_ff.nv_idx;
  assign nv_data_o = s_ff.nv_data;
  assign run_permit_o = s_ff.permit;
  assign status_o = s_ff.status;
  assign hold_active_o = s_ff.hold_act;
  assign hold_torque_o = s_ff.hold_tq;
  assign brake_release_o = s_ff.brk_rel;
  assign lag_trim_max_o = s_ff.lag;
  assign rest_trim_en_o = s_ff.rest[0];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  sequence s_run_end;
    run_active_i ##1 !run_active_i;
  endsequence
  sequence s_bad_thr_wr;
    sdo_req_i && sdo_wr_i && (sdo_index_i == IDX_THR) && (sdo_wdata_i > MAX_THR);
  endsequence
  sequence s_bad_rest_wr;
    sdo_req_i && sdo_wr_i && (sdo_index_i == IDX_REST) && (sdo_wdata_i > MAX_REST);
  endsequence

  property p_answer;
    sdo_req_i |=> (sdo_ack_o != sdo_abort_o);
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered once");

  property p_ro_write;
    sdo_req_i && sdo_wr_i && (sdo_index_i == IDX_SERIAL) |=> sdo_abort_o && !nv_save_o;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");

  property p_thr_range;
    s_bad_thr_wr |=> sdo_abort_o && $stable(s_ff.thr);
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("out-of-range threshold taken");

  property p_start_gate;
    !run_active_i && (s_ff.avg <= s_ff.thr) |=> !run_permit_o;
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("start permitted at low voltage");

  property p_mpow;
    ##1 status_o[STAT_MPOW] == ($past(s_ff.avg) > $past(s_ff.thr));
  endproperty
  a_mpow: assert property (p_mpow) else $error("motor power bit wrong");

  property p_sag;
    run_active_i && (s_ff.avg >= RUN_SAG_MIN) |=> run_permit_o;
  endproperty
  a_sag: assert property (p_sag) else $error("run refused above sag floor");

  property p_temp;
    $signed(temp_i) > $signed(s_ff.tlim) |=> status_o[STAT_TEXC];
  endproperty
  a_temp: assert property (p_temp) else $error("temperature flag missing");

  property p_lag_moving;
    sdo_req_i && sdo_wr_i && (sdo_index_i == IDX_LAG) && run_active_i |=> $stable(lag_trim_max_o) && sdo_abort_o;
  endproperty
  a_lag_moving: assert property (p_lag_moving) else $error("trim changed while moving");

  property p_hold;
    s_run_end ##0 (s_ff.hold_dur > 16'h0001) |=> hold_active_o [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("holding torque not applied");

  property p_brake;
    s_run_end ##0 (s_ff.brake > 16'h0001) |-> brake_release_o [*4];
  endproperty
  a_brake: assert property (p_brake) else $error("brake engaged too early");

  property p_peak;
    run_active_i && s_ff.run_d && !start_phase_i && !brake_phase_i |=> s_ff.peak >= $past(torque_i);
  endproperty
  a_peak: assert property (p_peak) else $error("peak torque missed");

  property p_peak_clear;
    run_active_i && !s_ff.run_d |=> (s_ff.peak == 16'h0000);
  endproperty
  a_peak_clear: assert property (p_peak_clear) else $error("peak not cleared at run start");

  property p_save;
    sdo_req_i && sdo_wr_i |=> (nv_save_o == sdo_ack_o);
  endproperty
  a_save: assert property (p_save) else $error("backup offer differs from write answer");

  property p_rest_range;
    s_bad_rest_wr |=> sdo_abort_o && $stable(rest_trim_en_o);
  endproperty
  a_rest_range: assert property (p_rest_range) else $error("out-of-range readjust value taken");

  property p_brake_run;
    run_active_i |=> brake_release_o;
  endproperty
  a_brake_run: assert property (p_brake_run) else $error("brake applied while running");

  property p_temp_clear;
    ($signed(temp_i) <= $signed(s_ff.tlim)) |=> !status_o[STAT_TEXC];
  endproperty
  a_temp_clear: assert property (p_temp_clear) else $error("temperature flag without excess");
endmodule

// file: dv/dmpb_master.sv
/*
  Service data master model that drives the request port of the bank.
  Assumes the bank registers its answer on the taking edge itself, ready by the next falling edge.
*/
`timescale 1ns/10ps
module dmpb_master (
  // Clock
  input wire logic clk_sys_i,
  // Request
  output logic sdo_req_o,
  output logic sdo_wr_o,
  output logic [15:0] sdo_index_o,
  output logic [15:0] sdo_wdata_o,
  // Answer
  input wire logic sdo_ack_i,
  input wire logic sdo_abort_i,
  input wire logic [15:0] sdo_rdata_i
);
  initial begin
    sdo_req_o = 1'b0;
    sdo_wr_o = 1'b0;
    sdo_index_o = 16'h0000;
    sdo_wdata_o = 16'h0000;
  end
  // One request, held over the taking edge; answer caught mid-cycle
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                      output logic ok, output logic [15:0] rd);
    @(posedge clk_sys_i);
    sdo_req_o <= 1'b1;
    sdo_wr_o <= wr;
    sdo_index_o <= idx;
    sdo_wdata_o <= wd;
    @(posedge clk_sys_i);
    // Released index and data lines carry the inverse so stale values never look valid
    sdo_req_o <= 1'b0;
    sdo_index_o <= ~idx;
    sdo_wdata_o <= ~wd;
    @(negedge clk_sys_i);
    ok = sdo_ack_i & ~sdo_abort_i;
    rd = sdo_rdata_i;
  endtask
endmodule

// file: dv/tb.sv
/*
  Self-checking bench of the parameter bank: defaults, ranges, voltage
  gating, run end timing, peak torque, temperature and backup replay.
  Assumes the master model in dmpb_master and a shortened millisecond.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module tb;
  import dmpb_pkg::*;
  localparam int CPM = 4;  // Short millisecond keeps the run brief
  logic clk_sys_i = 1'b0, rst_i = 1'b1, ok;
  logic sdo_req, sdo_wr, sdo_ack, sdo_abort, nv_wr = 1'b0, nv_save;
  logic [15:0] sdo_index, sdo_wdata, sdo_rdata, rd, nv_index = 16'h0000, nv_data = 16'h0000;
  logic [15:0] speed = 16'h0123, torque = 16'h0045, ulog = 16'h00f0, umot = 16'h0000, temp = 16'h0019;
  logic run = 1'b0, startp = 1'b0, brakep = 1'b0, permit, hold, brake, rest_en;
  logic [15:0] nv_idx_o, nv_dat_o, status, hold_tq, lag_max;
  int miscompares = 0, tests_run = 0, cycles = 0;
  logic [15:0] def_idx[7] = '{IDX_THR, IDX_WIN, IDX_TLIM, IDX_HOLD_DUR, IDX_BRAKE, IDX_LAG, IDX_REST};
  logic [15:0] def_val[7] = '{16'h00b9, 16'h0064, 16'h0046, 16'h00c8, 16'h03e8, 16'h0004, 16'h0000};
  logic [32:0] rng[13] = '{{IDX_THR, 16'h00b3, 1'b0}, {IDX_THR, 16'h00f1, 1'b0}, {IDX_THR, 16'h00f0, 1'b1},
    {IDX_THR, 16'h00b4, 1'b1}, {IDX_WIN, 16'h0063, 1'b0}, {IDX_WIN, 16'h03e9, 1'b0}, {IDX_WIN, 16'h03e8, 1'b1},
    {IDX_WIN, 16'h0064, 1'b1}, {IDX_REST, 16'h0002, 1'b0}, {IDX_HOLD_DUR, 16'h03e9, 1'b0},
    {IDX_BRAKE, 16'h0bb9, 1'b0}, {IDX_REST, 16'h0001, 1'b1}, {IDX_TLIM, 16'h0051, 1'b0}};

  always #12.5 clk_sys_i = ~clk_sys_i;

  dmpb_bank #(.CYC_PER_MS_P(CPM)) i_dmpb_bank (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sdo_req_i(sdo_req), .sdo_wr_i(sdo_wr),
    .sdo_index_i(sdo_index), .sdo_wdata_i(sdo_wdata), .sdo_ack_o(sdo_ack), .sdo_abort_o(sdo_abort),
    .sdo_rdata_o(sdo_rdata), .speed_i(speed), .torque_i(torque), .logic_volt_i(ulog),
    .motor_volt_i(umot), .temp_i(temp), .year_week_format_i(16'h2312), .serial_i(16'hbeef),
    .run_active_i(run), .start_phase_i(startp), .brake_phase_i(brakep), .nv_wr_i(nv_wr),
    .nv_index_i(nv_index), .nv_data_i(nv_data), .nv_save_o(nv_save), .nv_index_o(nv_idx_o),
    .nv_data_o(nv_dat_o), .run_permit_o(permit), .status_o(status), .hold_active_o(hold),
    .hold_torque_o(hold_tq), .brake_release_o(brake), .lag_trim_max_o(lag_max), .rest_trim_en_o(rest_en));

  dmpb_master i_dmpb_master (
    .clk_sys_i(clk_sys_i), .sdo_req_o(sdo_req), .sdo_wr_o(sdo_wr), .sdo_index_o(sdo_index),
    .sdo_wdata_o(sdo_wdata), .sdo_ack_i(sdo_ack), .sdo_abort_i(sdo_abort), .sdo_rdata_i(sdo_rdata));

  // ****************************************
  // Access helpers and closing
  // ****************************************
  task automatic rd_chk(input logic [15:0] idx, input logic [15:0] ex);
    i_dmpb_master.xfer(1'b0, idx, 16'h0000, ok, rd);
    `CHK("read answer", 1'b1, ok)
    `CHK("read data", ex, rd)
  endtask
  task automatic wr_chk(input logic [15:0] idx, input logic [15:0] wd, input logic ex);
    i_dmpb_master.xfer(1'b1, idx, wd, ok, rd);
    `CHK("write answer", ex, ok)
    `CHK("write save", ex, nv_save)
    `CHK("write refused", !ex, sdo_abort)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, well above the few thousand cycles the sequence needs
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      finish_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cyc(3);
    rst_i <= 1'b0;
    cyc(1);
    `CHK("lag max out", 16'h0004, lag_max)
    for (int i = 0; i < 7; i++) rd_chk(def_idx[i], def_val[i]);
    rd_chk(IDX_SPEED, 16'h0123);
    rd_chk(IDX_TORQUE, 16'h0045);
    rd_chk(IDX_ULOGIC, 16'h00f0);
    rd_chk(IDX_TEMP, 16'h0019);
    rd_chk(IDX_YW, 16'h2312);
    wr_chk(IDX_SERIAL, 16'h0001, 1'b0);
    rd_chk(IDX_SERIAL, 16'hbeef);
    i_dmpb_master.xfer(1'b0, 16'h2032, 16'h0000, ok, rd);
    `CHK("unmapped read", 1'b0, ok)
    `CHK("unmapped data", 16'h0000, rd)
    for (int i = 0; i < 13; i++) wr_chk(rng[i][32:17], rng[i][16:1], rng[i][0]);
    `CHK("save index", IDX_REST, nv_idx_o)
    `CHK("save data", 16'h0001, nv_dat_o)
    `CHK("readjust out", 1'b1, rest_en)
    rd_chk(IDX_THR, 16'h00b4);
    rd_chk(IDX_TLIM, 16'h0046);
    // Averaged voltage just above the lowest threshold
    @(posedge clk_sys_i) umot <= 16'h00b5;
    cyc(900);
    `CHK("permit idle", 1'b1, permit)
    `CHK("motor power", 1'b1, status[STAT_MPOW])
    rd_chk(IDX_UDRIVE, 16'h00b5);
    wr_chk(IDX_THR, 16'h00b5, 1'b1);
    cyc(2);
    `CHK("permit equal", 1'b0, permit)
    `CHK("power equal", 1'b0, status[STAT_MPOW])
    // Sag during a run down to the 17.5 V floor
    run <= 1'b1;
    umot <= 16'h00af;
    cyc(900);
    `CHK("permit sag", 1'b1, permit)
    umot <= 16'h00ae;
    cyc(900);
    `CHK("permit low", 1'b0, permit)
    wr_chk(IDX_LAG, 16'h0006, 1'b0);
    `CHK("lag kept", 16'h0004, lag_max)
    wr_chk(IDX_HOLD_DUR, 16'h0002, 1'b1);
    wr_chk(IDX_BRAKE, 16'h0005, 1'b1);
    wr_chk(IDX_HOLD_TQ, 16'h0123, 1'b1);
    `CHK("hold torque", 16'h0123, hold_tq)
    @(posedge clk_sys_i) run <= 1'b0;
    @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK("hold start", 1'b1, hold)
    `CHK("brake start", 1'b1, brake)
    cyc(3 * CPM + 1);
    `CHK("hold end", 1'b0, hold)
    `CHK("brake mid", 1'b1, brake)
    cyc(3 * CPM);
    `CHK("brake end", 1'b0, brake)
    wr_chk(IDX_LAG, 16'h000a, 1'b1);
    `CHK("lag set", 16'h000a, lag_max)
    // Peak ignores the start and brake-down phases
    @(posedge clk_sys_i) {run, startp, torque} <= {2'b11, 16'h0900};
    cyc(3);
    {startp, torque} <= {1'b0, 16'h0300};
    cyc(3);
    torque <= 16'h0500;
    cyc(3);
    {brakep, torque} <= {1'b1, 16'h0800};
    cyc(3);
    {run, brakep} <= 2'b00;
    rd_chk(IDX_PEAK, 16'h0500);
    @(posedge clk_sys_i) temp <= 16'h0047;
    cyc(3);
    `CHK("temp over", 1'b1, status[STAT_TEXC])
    temp <= 16'h0046;
    cyc(3);
    `CHK("temp at limit", 1'b0, status[STAT_TEXC])
    // Backup replay: legal value stored, illegal one dropped
    {nv_wr, nv_index, nv_data} <= {1'b1, IDX_BRAKE, 16'h01f4};
    cyc(1);
    nv_data <= 16'h0bb9;
    cyc(1);
    nv_wr <= 1'b0;
    rd_chk(IDX_BRAKE, 16'h01f4);
    finish_test();
  end
endmodule
